// File: src/tcc8_pkg.sv
// Notes on behaviour
// - 8-bit free-running up-counter, readable at two identical addresses; a write to either reloads it.
// - alternate counter read never clears the overflow flag.
// - writing either counter address reloads the counter with FCh.
// - counter reset and reload value is FCh in every mode.
// - clock select picks cpu/2, /4, /8 or second oscillator/8000.
// - rollover FFh to 00h sets the overflow flag in every mode.
// - overflow interrupt only when enabled and cpu mask clear; else pending.
// - overflow flag clears on primary counter access after status read saw it set.
// - counter runs in wait, freezes in halt, resumes from held count.
// - selected edge on capture pin latches counter into that capture register.
// - capture sets its flag; shared capture enable gates interrupt.
// - capture flag clears on capture register access after status read.
// - in single pulse or pwm mode only capture channel 2 captures.
// - capture pins always observed, even when driven as outputs.
// - both compare registers compared with counter each timer tick.
// - match sets compare flag (flag 1 not in pulse/pwm, flag 2 not in pwm), drives level if output enabled, may interrupt.
// - output disabled: pin is general i/o, interrupt still possible.
// - compare output latches are held low during reset.
// - compare registers are software read/write only, reset to 00h.
// - compare flag clears on compare register access after status read.
// - at cpu/2 match on equal; slower clocks match at value plus one.
// - force bit copies level to pin, no flag, ignored in pulse/pwm modes.
package tcc8_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [3:0] ADDR_CTRL_TWO  = 4'h1;
    localparam logic [3:0] ADDR_CTRL_ONE  = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;
    localparam logic [3:0] ADDR_CAPT1     = 4'h4;
    localparam logic [3:0] ADDR_CMP1      = 4'h5;
    localparam logic [3:0] ADDR_CNT_PRI   = 4'h6;
    localparam logic [3:0] ADDR_CNT_ALT   = 4'h7;
    localparam logic [3:0] ADDR_CAPT2     = 4'h8;
    localparam logic [3:0] ADDR_CMP2      = 4'h9;
    // ****************************************
    // control_reg_one fields
    // ****************************************
    localparam int C1_CAPT_IE  = 7;
    localparam int C1_CMP_IE   = 6;
    localparam int C1_OVF_IE   = 5;
    localparam int C1_FORCE2   = 4;
    localparam int C1_FORCE1   = 3;
    localparam int C1_LVL2     = 2;
    localparam int C1_EDGE1    = 1;
    localparam int C1_LVL1     = 0;
    // ****************************************
    // control_reg_two fields
    // ****************************************
    localparam int C2_OE1      = 7;
    localparam int C2_OE2      = 6;
    localparam int C2_PULSE    = 5;
    localparam int C2_PWM      = 4;
    localparam int C2_CLKSEL_H = 3;
    localparam int C2_CLKSEL_L = 2;
    localparam int C2_EDGE2    = 1;
    // ****************************************
    // status fields
    // ****************************************
    localparam int ST_CAPT1 = 7;
    localparam int ST_CMP1  = 6;
    localparam int ST_OVF   = 5;
    localparam int ST_CAPT2 = 4;
    localparam int ST_CMP2  = 3;
    localparam int ST_DIS   = 2;
    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [7:0] CNT_RELOAD   = 8'hFC;
    localparam logic [7:0] CMP_RESET    = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [1:0] CLK_DIV2     = 2'h0;
    localparam logic [1:0] CLK_DIV4     = 2'h1;
    localparam logic [1:0] CLK_DIV8     = 2'h2;
    localparam logic [1:0] CLK_OSC      = 2'h3;
    localparam int         OSC_DIV      = 8000;
endpackage

// File: src/tcc8_timer.sv
module tcc8_timer (
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    // register port
    input  wire logic [3:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // system
    input  wire logic       OSC2_TICK_I,
    input  wire logic       HALT_I,
    input  wire logic       CPU_MASK_I,
    // pins
    input  wire logic       CAPT_PIN1_I,
    input  wire logic       CAPT_PIN2_I,
    output logic            CMP_PIN1_O,
    output logic            CMP_PIN2_O,
    output logic            CMP_PIN1_OE_N_O,
    output logic            CMP_PIN2_OE_N_O,
    output logic            TIMER_IRQ_O
);
    logic [7:0]  ctrl1_r, ctrl2_r, cnt_r, capt1_r, capt2_r, cmp1_r, cmp2_r;
    logic        ovf_r, cf1_r, cf2_r, mf1_r, mf2_r, dis_r, pin1_r, pin2_r;
    logic        ovf_seen_r, cf1_seen_r, cf2_seen_r, mf1_seen_r, mf2_seen_r;
    logic        cap1_d_r, cap2_d_r;
    logic [2:0]  pre_r;
    logic [12:0] osc_r;
    logic        tick, run, mode_alt, wr_cnt, acc_cnt, rd_st;
    logic        ev1, ev2, m1, m2, f1_prev_r, f2_prev_r;
    logic [1:0]  csel;

    // ****************************************
    // prescaler
    // ****************************************
    assign csel     = ctrl2_r[tcc8_pkg::C2_CLKSEL_H:tcc8_pkg::C2_CLKSEL_L];
    assign mode_alt = ctrl2_r[tcc8_pkg::C2_PULSE] | ctrl2_r[tcc8_pkg::C2_PWM];
    // halt freezes the count, wait does not touch it
    assign run      = ~HALT_I & ~dis_r;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            pre_r <= 3'h0;
            osc_r <= 13'h0;
        end else if (run) begin
            pre_r <= pre_r + 3'h1;
            if (OSC2_TICK_I) begin
                osc_r <= (osc_r == 13'(tcc8_pkg::OSC_DIV - 1)) ? 13'h0 : osc_r + 13'h1;
            end
        end
    end

    always_comb begin
        unique case (csel)
            tcc8_pkg::CLK_DIV2: tick = run & pre_r[0];
            tcc8_pkg::CLK_DIV4: tick = run & (pre_r[1:0] == 2'h3);
            tcc8_pkg::CLK_DIV8: tick = run & (pre_r == 3'h7);
            default:            tick = run & OSC2_TICK_I &
                                       (osc_r == 13'(tcc8_pkg::OSC_DIV - 1));
        endcase
    end

    // ****************************************
    // counter
    // ****************************************
    assign wr_cnt  = WR_I & ((ADDR_I == tcc8_pkg::ADDR_CNT_PRI) |
                             (ADDR_I == tcc8_pkg::ADDR_CNT_ALT));
    assign acc_cnt = (WR_I | RD_I) & (ADDR_I == tcc8_pkg::ADDR_CNT_PRI);
    assign rd_st   = RD_I & (ADDR_I == tcc8_pkg::ADDR_STATUS);

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            cnt_r <= tcc8_pkg::CNT_RELOAD;
        end else if (wr_cnt) begin
            cnt_r <= tcc8_pkg::CNT_RELOAD;
        end else if (tick) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // ****************************************
    // capture
    // ****************************************
    // pins are sampled raw whether or not the port drives them
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            cap1_d_r <= 1'b0;
            cap2_d_r <= 1'b0;
        end else begin
            cap1_d_r <= CAPT_PIN1_I;
            cap2_d_r <= CAPT_PIN2_I;
        end
    end

    // edge bit high selects rising edge
    assign ev1 = ~mode_alt & (ctrl1_r[tcc8_pkg::C1_EDGE1] ?
                 (CAPT_PIN1_I & ~cap1_d_r) : (~CAPT_PIN1_I & cap1_d_r));
    assign ev2 = ctrl2_r[tcc8_pkg::C2_EDGE2] ?
                 (CAPT_PIN2_I & ~cap2_d_r) : (~CAPT_PIN2_I & cap2_d_r);

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            capt1_r <= 8'h00;
            capt2_r <= 8'h00;
        end else begin
            if (ev1) capt1_r <= cnt_r;
            if (ev2) capt2_r <= cnt_r;
        end
    end

    // ****************************************
    // compare
    // ****************************************
    // judged on the count about to leave, so the flag lands with the new count:
    // at /2 the arriving value, slower clocks one count later
    function automatic logic hit(input logic [7:0] c, input logic [7:0] v,
                                 input logic [1:0] s);
        hit = (s == tcc8_pkg::CLK_DIV2) ? ((c + 8'h01) == v) : (c == v);
    endfunction

    // compare evaluated on each timer tick
    assign m1 = tick & hit(cnt_r, cmp1_r, csel);
    assign m2 = tick & hit(cnt_r, cmp2_r, csel);

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            f1_prev_r <= 1'b0;
            f2_prev_r <= 1'b0;
        end else begin
            f1_prev_r <= ctrl1_r[tcc8_pkg::C1_FORCE1];
            f2_prev_r <= ctrl1_r[tcc8_pkg::C1_FORCE2];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            pin1_r <= 1'b0;
            pin2_r <= 1'b0;
        end else begin
            if (ctrl2_r[tcc8_pkg::C2_OE1] & (m1 | (~mode_alt &
                ctrl1_r[tcc8_pkg::C1_FORCE1] & ~f1_prev_r))) begin
                pin1_r <= ctrl1_r[tcc8_pkg::C1_LVL1];
            end
            if (ctrl2_r[tcc8_pkg::C2_OE2] & (m2 | (~mode_alt &
                ctrl1_r[tcc8_pkg::C1_FORCE2] & ~f2_prev_r))) begin
                pin2_r <= ctrl1_r[tcc8_pkg::C1_LVL2];
            end
        end
    end

    // disabled output releases the pin to general i/o
    assign CMP_PIN1_O      = pin1_r;
    assign CMP_PIN2_O      = pin2_r;
    assign CMP_PIN1_OE_N_O = ~ctrl2_r[tcc8_pkg::C2_OE1] | dis_r;
    assign CMP_PIN2_OE_N_O = ~ctrl2_r[tcc8_pkg::C2_OE2] | dis_r;

    // ****************************************
    // flags: set wins over clear
    // ****************************************
    function automatic logic flag_nxt(input logic f, input logic set,
                                      input logic seen, input logic acc);
        flag_nxt = set | (f & ~(seen & acc));
    endfunction

    function automatic logic seen_nxt(input logic f, input logic seen,
                                      input logic rd, input logic acc);
        seen_nxt = f & (rd | (seen & ~acc));
    endfunction

    logic acc_c1, acc_c2, acc_m1, acc_m2;
    assign acc_c1 = (WR_I | RD_I) & (ADDR_I == tcc8_pkg::ADDR_CAPT1);
    assign acc_c2 = (WR_I | RD_I) & (ADDR_I == tcc8_pkg::ADDR_CAPT2);
    assign acc_m1 = (WR_I | RD_I) & (ADDR_I == tcc8_pkg::ADDR_CMP1);
    assign acc_m2 = (WR_I | RD_I) & (ADDR_I == tcc8_pkg::ADDR_CMP2);

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ovf_r <= 1'b0;
            ovf_seen_r <= 1'b0;
        end else begin
            ovf_r      <= flag_nxt(ovf_r, tick & (cnt_r == 8'hFF) & ~wr_cnt,
                                   ovf_seen_r, acc_cnt);
            ovf_seen_r <= seen_nxt(ovf_r, ovf_seen_r, rd_st, acc_cnt);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            cf1_r <= 1'b0;
            cf2_r <= 1'b0;
            cf1_seen_r <= 1'b0;
            cf2_seen_r <= 1'b0;
        end else begin
            cf1_r      <= flag_nxt(cf1_r, ev1, cf1_seen_r, acc_c1);
            cf2_r      <= flag_nxt(cf2_r, ev2, cf2_seen_r, acc_c2);
            cf1_seen_r <= seen_nxt(cf1_r, cf1_seen_r, rd_st, acc_c1);
            cf2_seen_r <= seen_nxt(cf2_r, cf2_seen_r, rd_st, acc_c2);
        end
    end

    // flag 1 never set in pulse/pwm, flag 2 not set in pwm
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            mf1_r <= 1'b0;
            mf2_r <= 1'b0;
            mf1_seen_r <= 1'b0;
            mf2_seen_r <= 1'b0;
        end else begin
            mf1_r      <= flag_nxt(mf1_r, m1 & ~mode_alt, mf1_seen_r, acc_m1);
            mf2_r      <= flag_nxt(mf2_r, m2 & ~ctrl2_r[tcc8_pkg::C2_PWM],
                                   mf2_seen_r, acc_m2);
            mf1_seen_r <= seen_nxt(mf1_r, mf1_seen_r, rd_st, acc_m1);
            mf2_seen_r <= seen_nxt(mf2_r, mf2_seen_r, rd_st, acc_m2);
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ctrl1_r <= tcc8_pkg::CTRL_RESET;
            ctrl2_r <= tcc8_pkg::CTRL_RESET;
            cmp1_r  <= tcc8_pkg::CMP_RESET;
            cmp2_r  <= tcc8_pkg::CMP_RESET;
            dis_r   <= 1'b0;
        end else if (WR_I) begin
            unique case (ADDR_I)
                tcc8_pkg::ADDR_CTRL_ONE: ctrl1_r <= WDATA_I;
                tcc8_pkg::ADDR_CTRL_TWO: ctrl2_r <= {WDATA_I[7:1], 1'b0};
                tcc8_pkg::ADDR_STATUS:   dis_r   <= WDATA_I[tcc8_pkg::ST_DIS];
                tcc8_pkg::ADDR_CMP1:     cmp1_r  <= WDATA_I;
                tcc8_pkg::ADDR_CMP2:     cmp2_r  <= WDATA_I;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            unique case (ADDR_I)
                tcc8_pkg::ADDR_CTRL_ONE: RDATA_O <= ctrl1_r;
                tcc8_pkg::ADDR_CTRL_TWO: RDATA_O <= ctrl2_r;
                tcc8_pkg::ADDR_STATUS:   RDATA_O <= {cf1_r, mf1_r, ovf_r, cf2_r, mf2_r,
                                                     dis_r, 2'h0};
                tcc8_pkg::ADDR_CAPT1:    RDATA_O <= capt1_r;
                tcc8_pkg::ADDR_CAPT2:    RDATA_O <= capt2_r;
                tcc8_pkg::ADDR_CMP1:     RDATA_O <= cmp1_r;
                tcc8_pkg::ADDR_CMP2:     RDATA_O <= cmp2_r;
                tcc8_pkg::ADDR_CNT_PRI,
                tcc8_pkg::ADDR_CNT_ALT:  RDATA_O <= cnt_r;
                default:                 RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    // requests stay pending in the flags until the mask opens
    assign TIMER_IRQ_O = ~CPU_MASK_I & (
        (ctrl1_r[tcc8_pkg::C1_OVF_IE]  & ovf_r) |
        (ctrl1_r[tcc8_pkg::C1_CAPT_IE] & (cf1_r | cf2_r)) |
        (ctrl1_r[tcc8_pkg::C1_CMP_IE]  & (mf1_r | mf2_r)));
endmodule

// File: dv/tcc8_timer_assertions.sv
module tcc8_timer_chk (
    // clock and reset
    input wire logic       CLK_I,
    input wire logic       RSTN_I,
    // register port
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    // system and pins
    input wire logic       CPU_MASK_I,
    input wire logic       CMP_PIN1_O,
    input wire logic       CMP_PIN2_O,
    input wire logic       CMP_PIN1_OE_N_O,
    input wire logic       CMP_PIN2_OE_N_O,
    input wire logic       TIMER_IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // ********
    // port relations
    // ********
    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not idle");
    a_unmapped_read: assert property (RD_I && (ADDR_I == 4'h0 || ADDR_I > 4'h9)
        |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
    a_status_rsvd: assert property (RD_I && ADDR_I == tcc8_pkg::ADDR_STATUS
        |=> RDATA_O[1:0] == 2'h0) else $error("status spare bits set");
    a_cnt_reload: assert property (WR_I && ADDR_I[3:1] == 3'h3 ##1
        RD_I && ADDR_I[3:1] == 3'h3 |=> RDATA_O == tcc8_pkg::CNT_RELOAD)
        else $error("counter not reloaded");
    a_cmp_readback: assert property (WR_I && ADDR_I == tcc8_pkg::ADDR_CMP1 ##1
        RD_I && ADDR_I == tcc8_pkg::ADDR_CMP1 |=> RDATA_O == $past(WDATA_I, 2))
        else $error("compare register readback wrong");
    a_irq_masked: assert property (CPU_MASK_I |-> !TIMER_IRQ_O)
        else $error("irq while masked");
    a_reset_pins: assert property ($rose(RSTN_I) |-> !CMP_PIN1_O && !CMP_PIN2_O &&
        CMP_PIN1_OE_N_O && CMP_PIN2_OE_N_O && !TIMER_IRQ_O) else $error("pins not reset");
    // enables only move when software writes control register two or the status register
    a_oe_by_write: assert property ($changed(CMP_PIN1_OE_N_O) ||
        $changed(CMP_PIN2_OE_N_O) |-> $past(WR_I)) else $error("output enable moved without write");
endmodule

bind tcc8_timer tcc8_timer_chk u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CPU_MASK_I(CPU_MASK_I),
    .CMP_PIN1_O(CMP_PIN1_O), .CMP_PIN2_O(CMP_PIN2_O), .CMP_PIN1_OE_N_O(CMP_PIN1_OE_N_O),
    .CMP_PIN2_OE_N_O(CMP_PIN2_OE_N_O), .TIMER_IRQ_O(TIMER_IRQ_O));

// File: dv/tcc8_cpu_model.sv
module tcc8_cpu_model (
    // clock
    input  wire logic       clk_i,
    // register port
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // ********
    // one-cycle strobes, read data sampled once settled
    // ********
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 v = rdata_i;
    endtask
    // read follows write with no gap
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] v, output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 q = rdata_i;
    endtask
endmodule

// File: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rstn, osc, halt, mask, cap1, cap2, wr, rd, p1, p2, oe1, oe2, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    int         bad_count, checks_done;
    int         span [4] = '{8, 16, 32, 24000};
    logic [3:0] raddr [6] = '{tcc8_pkg::ADDR_CMP1, tcc8_pkg::ADDR_CMP2,
        tcc8_pkg::ADDR_CTRL_ONE, tcc8_pkg::ADDR_CTRL_TWO, 4'h0, 4'hF};
    tcc8_timer dut (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .OSC2_TICK_I(osc), .HALT_I(halt), .CPU_MASK_I(mask),
        .CAPT_PIN1_I(cap1), .CAPT_PIN2_I(cap2), .CMP_PIN1_O(p1), .CMP_PIN2_O(p2),
        .CMP_PIN1_OE_N_O(oe1), .CMP_PIN2_OE_N_O(oe2), .TIMER_IRQ_O(irq));
    tcc8_cpu_model cpu (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // oscillator tick every second cycle
    always @(posedge clk) osc <= ~osc;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_rng(input string n, input logic [7:0] lo, hi, g);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            bad_count++;
            $display("mismatch %s expected %h..%h seen %h", n, lo, hi, g);
        end
    endtask
    task automatic sbit(input int b, input logic e);
        logic [7:0] s;
        cpu.rd(tcc8_pkg::ADDR_STATUS, s);
        chk($sformatf("status bit %0d", b), {7'h0, e}, {7'h0, s[b]});
    endtask
    task automatic irqc(input logic e);
        #1 chk("irq", {7'h0, e}, {7'h0, irq});
    endtask
    // counter only moves inside this window
    task automatic run(input int n);
        @(posedge clk) halt <= 1'b0;
        repeat (n) @(posedge clk);
        @(posedge clk) halt <= 1'b1;
    endtask
    task automatic pins(input logic a, input logic b);
        @(posedge clk) begin
            cap1 <= a;
            cap2 <= b;
        end
        repeat (3) @(posedge clk);
    endtask
    // one timer tick per step, so the count when the flag shows is exact
    task automatic cmp_at(input logic [7:0] sel, input int n, input logic [7:0] e);
        logic [7:0] s;
        cpu.wr(tcc8_pkg::ADDR_CTRL_TWO, sel);
        cpu.wr(tcc8_pkg::ADDR_CNT_PRI, 8'h00);
        s = 8'h00;
        repeat (12) if (!s[tcc8_pkg::ST_CMP2]) begin
            run(n);
            cpu.rd(tcc8_pkg::ADDR_STATUS, s);
        end
        cpu.rd(tcc8_pkg::ADDR_CNT_ALT, d);
        chk("match count", e, d);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        test_done();
    end
    // ********
    // test sequence
    // ********
    initial begin
        {rstn, osc, halt, mask, cap1} = 5'h00;
        cap2 = 1'b1;
        bad_count = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (raddr[i]) begin
            cpu.rd(raddr[i], d);
            chk("reset value", 8'h00, d);
        end
        cpu.wr_rd(tcc8_pkg::ADDR_CMP1, 8'h5A, d);
        chk("cmp1", 8'h5A, d);
        cpu.wr_rd(tcc8_pkg::ADDR_CMP2, 8'hA5, d);
        chk("cmp2", 8'hA5, d);
        @(posedge clk) halt <= 1'b1;
        cpu.wr_rd(tcc8_pkg::ADDR_CNT_ALT, 8'h33, d);
        chk("cnt reload", 8'hFC, d);
        cpu.wr(tcc8_pkg::ADDR_CNT_PRI, 8'hC3);
        repeat (20) @(posedge clk);
        cpu.rd(tcc8_pkg::ADDR_CNT_PRI, d);
        chk("cnt held", 8'hFC, d);
        cpu.rd(tcc8_pkg::ADDR_CNT_ALT, d);
        chk("cnt alt", 8'hFC, d);
        for (int s = 0; s < 4; s++) begin
            cpu.wr(tcc8_pkg::ADDR_CTRL_TWO, {4'h0, s[1:0], 2'h0});
            cpu.wr(tcc8_pkg::ADDR_CNT_PRI, 8'h00);
            run(span[s]);
            cpu.rd(tcc8_pkg::ADDR_CNT_PRI, d);
            chk_rng("cnt rate", s == 3 ? 8'h01 : 8'h03, s == 3 ? 8'h02 : 8'h05,
                    8'(d - 8'hFC));
        end
        $display("test counter done");
        cpu.wr(tcc8_pkg::ADDR_CTRL_TWO, 8'h00);
        cpu.rd(tcc8_pkg::ADDR_STATUS, d);
        cpu.rd(tcc8_pkg::ADDR_CNT_PRI, d);
        sbit(tcc8_pkg::ST_OVF, 1'b0);
        cpu.wr(tcc8_pkg::ADDR_CNT_ALT, 8'h00);
        run(20);
        sbit(tcc8_pkg::ST_OVF, 1'b1);
        cpu.wr(tcc8_pkg::ADDR_CTRL_ONE, 8'h20);
        irqc(1'b1);
        @(posedge clk) mask <= 1'b1;
        irqc(1'b0);
        @(posedge clk) mask <= 1'b0;
        irqc(1'b1);
        cpu.rd(tcc8_pkg::ADDR_CNT_ALT, d);
        sbit(tcc8_pkg::ST_OVF, 1'b1);
        cpu.rd(tcc8_pkg::ADDR_CNT_PRI, d);
        sbit(tcc8_pkg::ST_OVF, 1'b0);
        irqc(1'b0);
        $display("test overflow done");
        cpu.wr(tcc8_pkg::ADDR_CMP1, 8'h10);
        cpu.wr(tcc8_pkg::ADDR_CTRL_ONE, 8'h05);
        cpu.wr(tcc8_pkg::ADDR_CTRL_TWO, 8'h80);
        cpu.rd(tcc8_pkg::ADDR_STATUS, d);
        cpu.rd(tcc8_pkg::ADDR_CMP1, d);
        cpu.wr(tcc8_pkg::ADDR_CMP2, 8'h10);
        sbit(tcc8_pkg::ST_CMP1, 1'b0);
        sbit(tcc8_pkg::ST_CMP2, 1'b0);
        cpu.wr(tcc8_pkg::ADDR_CNT_PRI, 8'h00);
        run(50);
        sbit(tcc8_pkg::ST_CMP1, 1'b1);
        sbit(tcc8_pkg::ST_CMP2, 1'b1);
        chk("pin1", 8'h01, {7'h0, p1});
        chk("oe1", 8'h00, {7'h0, oe1});
        chk("oe2", 8'h01, {7'h0, oe2});
        chk("pin2", 8'h00, {7'h0, p2});
        cpu.wr(tcc8_pkg::ADDR_CTRL_ONE, 8'h40);
        irqc(1'b1);
        cpu.rd(tcc8_pkg::ADDR_STATUS, d);
        cpu.rd(tcc8_pkg::ADDR_CMP1, d);
        cpu.wr(tcc8_pkg::ADDR_CTRL_ONE, 8'h08);
        repeat (2) @(posedge clk);
        chk("pin1 forced", 8'h00, {7'h0, p1});
        sbit(tcc8_pkg::ST_CMP1, 1'b0);
        cpu.wr(tcc8_pkg::ADDR_CTRL_TWO, 8'hA0);
        cpu.wr(tcc8_pkg::ADDR_CTRL_ONE, 8'h01);
        cpu.wr(tcc8_pkg::ADDR_CTRL_ONE, 8'h09);
        repeat (2) @(posedge clk);
        chk("pin1 pulse mode", 8'h00, {7'h0, p1});
        cpu.rd(tcc8_pkg::ADDR_STATUS, d);
        cpu.wr(tcc8_pkg::ADDR_CMP2, 8'h02);
        cmp_at(8'h00, 1, 8'h02);
        cpu.wr(tcc8_pkg::ADDR_CMP2, 8'h02);
        cmp_at(8'h04, 3, 8'h03);
        cpu.wr(tcc8_pkg::ADDR_CTRL_TWO, 8'hA0);
        $display("test compare done");
        cpu.wr(tcc8_pkg::ADDR_CTRL_ONE, 8'h82);
        cpu.wr(tcc8_pkg::ADDR_CNT_PRI, 8'h00);
        pins(1'b1, 1'b0);
        sbit(tcc8_pkg::ST_CAPT1, 1'b0);
        sbit(tcc8_pkg::ST_CAPT2, 1'b1);
        irqc(1'b1);
        cpu.rd(tcc8_pkg::ADDR_CAPT2, d);
        chk("capt2", 8'hFC, d);
        sbit(tcc8_pkg::ST_CAPT2, 1'b0);
        cpu.wr(tcc8_pkg::ADDR_CTRL_TWO, 8'h00);
        pins(1'b0, 1'b0);
        sbit(tcc8_pkg::ST_CAPT1, 1'b0);
        pins(1'b1, 1'b0);
        sbit(tcc8_pkg::ST_CAPT1, 1'b1);
        cpu.wr(tcc8_pkg::ADDR_CAPT1, 8'h55);
        cpu.rd(tcc8_pkg::ADDR_CAPT1, d);
        chk("capt1", 8'hFC, d);
        sbit(tcc8_pkg::ST_CAPT1, 1'b0);
        irqc(1'b0);
        $display("test capture done");
        test_done();
    end
endmodule
